// >>> logic/iap_flash_program_controller.sv
// apb-attached in-application programming controller for a 16-bit flash program memory
`timescale 1ns/100ps
module iap_flash_program_controller #(
  parameter int unsigned ERASE_SHORT_CYC = iap_pkg::ERASE_SHORT_CYC,
  parameter int unsigned WRITE_SHORT_CYC = iap_pkg::WRITE_SHORT_CYC,
  parameter int unsigned ERASE_LONG_CYC = iap_pkg::ERASE_LONG_CYC,
  parameter int unsigned WRITE_LONG_CYC = iap_pkg::WRITE_LONG_CYC
) (
  input wire logic pclk, // system clock, 200 MHz
  input wire logic presetn, // asynchronous reset, active low
  input wire logic [11:0] paddr, // apb byte address
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction, high for write
  input wire logic [31:0] pwdata, // apb write data
  input wire logic [3:0] pstrb, // apb byte strobes, lane 0 used
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  output logic irq, // level interrupt
  output logic chip_reset_req, // one-cycle chip reset request
  output logic [13:0] flash_addr, // flash word address
  output logic [15:0] flash_wdata, // word to program
  output logic flash_wr, // one-cycle word program strobe
  output logic flash_erase, // page erase level
  output logic flash_rd, // one-cycle read strobe
  input wire logic [15:0] flash_rdata // read word, valid the cycle after flash_rd
);
  iap_pkg::state_s r;
  iap_pkg::state_s n;
  logic acc;
  logic wr;
  logic idle;
  logic ld;
  logic hit;
  logic [7:0] rd_byte;
  logic [3:0] ev;
  logic buf_we;
  logic [4:0] buf_idx;
  logic [15:0] buf_wdata;
  logic [15:0] buf_rdata;
  logic pattern_ok;

  iap_write_buffer u_buf (
    .pclk(pclk),
    .we(buf_we),
    .idx(buf_idx),
    .wdata(buf_wdata),
    .rdata(buf_rdata)
  );

  //////////////////////////////////////////////////////////////////////////////
  // register read mux

  always_comb begin
    hit = 1'b1;
    rd_byte = 8'h00;
    case (paddr)
      iap_pkg::OFF_CTRL: rd_byte = {r.ewen, r.mode, r.unlock, r.wstart, r.rden, r.rstart};
      iap_pkg::OFF_KEY: rd_byte = r.rst_key;
      iap_pkg::OFF_AUX: rd_byte = {6'h00, r.time_sel, r.bclear};
      iap_pkg::OFF_ADDR_LOW: rd_byte = r.addr[7:0];
      iap_pkg::OFF_ADDR_HIGH: rd_byte = {2'h0, r.addr[13:8]};
      iap_pkg::OFF_INT_STAT: rd_byte = {4'h0, r.irq_stat};
      iap_pkg::OFF_INT_MASK: rd_byte = {4'h0, r.irq_mask};
      default: begin
        hit = 1'b0;
        for (int i = 0; i < iap_pkg::DATA_REGS; i++) begin
          if (paddr == iap_pkg::OFF_DATA_BASE + 12'(iap_pkg::DATA_STRIDE * i)) begin
            hit = 1'b1;
            rd_byte = (i % 2 == 1) ? r.data[i / 2][15:8] : r.data[i / 2][7:0];
          end
        end
      end
    endcase
  end

  // the six unlock bytes are compared as three words
  assign pattern_ok = (r.data[1] == iap_pkg::UNLOCK_WORD1) && (r.data[2] == iap_pkg::UNLOCK_WORD2) &&
                      (r.data[3] == iap_pkg::UNLOCK_WORD3);

  //////////////////////////////////////////////////////////////////////////////
  // next-state logic

  always_comb begin
    n = r;
    n.chip_rst = 1'b0;
    n.f_wr = 1'b0;
    n.f_rd = 1'b0;
    ev = 4'h0;
    ld = 1'b0;
    buf_we = 1'b0;
    buf_idx = r.widx;
    buf_wdata = 16'h0000;
    idle = (r.fsm == iap_pkg::IDLE);
    // access takes effect on the edge where pready is seen high
    acc = psel & penable & r.pready;
    wr = acc & pwrite & pstrb[0];
    n.pready = psel & penable & ~r.pready;
    n.pslverr = 1'b0;
    if (psel & penable & ~r.pready) begin
      n.pslverr = ~hit;
      n.prdata = {24'h000000, rd_byte};
    end

    if (wr) begin
      case (paddr)
        iap_pkg::OFF_CTRL: begin
          n.ewen = r.ewen & pwdata[iap_pkg::BIT_EWEN];
          n.mode = pwdata[iap_pkg::BIT_MODE_LO +: 3];
          n.rden = pwdata[iap_pkg::BIT_RDEN];
          if (idle && !r.unlock && pwdata[iap_pkg::BIT_UNLOCK] &&
              pwdata[iap_pkg::BIT_MODE_LO +: 3] == iap_pkg::MODE_UNLOCK) begin
            n.unlock = 1'b1;
            n.ucnt = iap_pkg::UNLOCK_WINDOW_CYC;
          end
          // erase and write both need the enable status; mode decides which
          if (idle && !r.wstart && !r.rstart && !r.bclear && pwdata[iap_pkg::BIT_WSTART] && r.ewen &&
              (pwdata[iap_pkg::BIT_MODE_LO +: 3] == iap_pkg::MODE_WRITE ||
               pwdata[iap_pkg::BIT_MODE_LO +: 3] == iap_pkg::MODE_ERASE)) begin
            n.wstart = 1'b1;
          end
          // read enable must already be set before the start write
          if (idle && !r.wstart && !r.rstart && !r.bclear && pwdata[iap_pkg::BIT_RSTART] && r.rden &&
              pwdata[iap_pkg::BIT_RDEN] &&
              pwdata[iap_pkg::BIT_MODE_LO +: 3] == iap_pkg::MODE_READ) begin
            n.rstart = 1'b1;
          end
        end
        iap_pkg::OFF_KEY: begin
          n.rst_key = pwdata[7:0];
          n.chip_rst = (pwdata[7:0] == iap_pkg::CHIP_RESET_KEY);
        end
        iap_pkg::OFF_AUX: begin
          n.time_sel = pwdata[iap_pkg::BIT_TSEL];
          if (idle && !r.wstart && !r.rstart && !r.bclear && pwdata[iap_pkg::BIT_BCLEAR]) begin
            n.bclear = 1'b1;
          end
        end
        iap_pkg::OFF_ADDR_LOW: n.addr[7:0] = pwdata[7:0];
        iap_pkg::OFF_ADDR_HIGH: n.addr[13:8] = pwdata[5:0];
        iap_pkg::OFF_INT_STAT: n.irq_stat = r.irq_stat & ~pwdata[3:0];
        iap_pkg::OFF_INT_MASK: n.irq_mask = pwdata[3:0];
        default: begin
          for (int i = 0; i < iap_pkg::DATA_REGS; i++) begin
            if (paddr == iap_pkg::OFF_DATA_BASE + 12'(iap_pkg::DATA_STRIDE * i)) begin
              if (i % 2 == 1) begin
                n.data[i / 2][15:8] = pwdata[7:0];
              end else begin
                n.data[i / 2][7:0] = pwdata[7:0];
              end
            end
          end
        end
      endcase
    end

    // high data byte commits the whole word; loads are dropped while the fsm owns the buffer
    if (wr && paddr == iap_pkg::OFF_DATA_BASE + 12'(iap_pkg::DATA_STRIDE) && idle && r.ewen) begin
      ld = 1'b1;
      buf_we = 1'b1;
      buf_idx = r.addr[4:0];
      buf_wdata = {pwdata[7:0], r.data[0][7:0]};
      if (r.addr[4:0] != iap_pkg::PAGE_LAST) begin
        n.addr = r.addr + 14'h0001;
      end
    end

    //////////////////////////////////////////////////////////////////////////////
    // unlock window, the trigger drops on timeout whatever the pattern was
    if (r.unlock) begin
      if (pattern_ok) begin
        n.ewen = 1'b1;
      end
      if (r.ucnt == 12'h001) begin
        n.unlock = 1'b0;
        ev[iap_pkg::EV_UNLOCK_END] = 1'b1;
      end else begin
        n.ucnt = r.ucnt - 12'h001;
      end
    end

    //////////////////////////////////////////////////////////////////////////////
    // operation sequencer
    case (r.fsm)
      iap_pkg::IDLE: begin
        if (r.wstart) begin
          if (r.mode == iap_pkg::MODE_ERASE) begin
            n.fsm = iap_pkg::ERASE;
            n.f_erase = 1'b1;
            n.f_addr = {r.addr[13:5], 5'h00};
            n.cnt = r.time_sel ? 20'(ERASE_LONG_CYC) : 20'(ERASE_SHORT_CYC);
          end else begin
            n.fsm = iap_pkg::WR_SHIFT;
            n.widx = 5'h00;
          end
        end else if (r.rstart) begin
          n.fsm = iap_pkg::RD_ISSUE;
          n.f_rd = 1'b1;
          n.f_addr = r.addr;
        end else if (r.bclear) begin
          n.fsm = iap_pkg::CLR;
          n.widx = 5'h00;
        end
      end
      iap_pkg::ERASE: begin
        if (r.cnt == 20'h00001) begin
          n.f_erase = 1'b0;
          n.wstart = 1'b0;
          ev[iap_pkg::EV_OP_DONE] = 1'b1;
          n.fsm = iap_pkg::IDLE;
        end else begin
          n.cnt = r.cnt - 20'h00001;
        end
      end
      iap_pkg::WR_SHIFT: begin
        // the whole page streams out, one word a cycle, before the program time
        n.f_wr = 1'b1;
        n.f_addr = {r.addr[13:5], r.widx};
        n.f_wdata = buf_rdata;
        n.widx = r.widx + 5'h01;
        if (r.widx == iap_pkg::PAGE_LAST) begin
          n.fsm = iap_pkg::WR_WAIT;
          n.cnt = r.time_sel ? 20'(WRITE_LONG_CYC) : 20'(WRITE_SHORT_CYC);
        end
      end
      iap_pkg::WR_WAIT: begin
        if (r.cnt == 20'h00001) begin
          n.fsm = iap_pkg::CLR;
          n.widx = 5'h00;
        end else begin
          n.cnt = r.cnt - 20'h00001;
        end
      end
      iap_pkg::CLR: begin
        buf_we = 1'b1;
        n.widx = r.widx + 5'h01;
        if (r.widx == iap_pkg::PAGE_LAST) begin
          n.fsm = iap_pkg::IDLE;
          if (r.wstart) begin
            n.wstart = 1'b0;
            ev[iap_pkg::EV_OP_DONE] = 1'b1;
          end
          if (r.bclear) begin
            n.bclear = 1'b0;
            ev[iap_pkg::EV_CLR_DONE] = 1'b1;
          end
        end
      end
      iap_pkg::RD_ISSUE: n.fsm = iap_pkg::RD_CAPT;
      iap_pkg::RD_CAPT: begin
        n.data[0] = flash_rdata;
        n.rstart = 1'b0;
        ev[iap_pkg::EV_RD_DONE] = 1'b1;
        n.fsm = iap_pkg::IDLE;
      end
      default: n.fsm = iap_pkg::IDLE;
    endcase

    // events win over a same-cycle write-one clear
    n.irq_stat = n.irq_stat | ev;
    n.irq = |(n.irq_stat & n.irq_mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= iap_pkg::STATE_RESET;
    end else begin
      r <= n;
    end
  end

  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign irq = r.irq;
  assign chip_reset_req = r.chip_rst;
  assign flash_addr = r.f_addr;
  assign flash_wdata = r.f_wdata;
  assign flash_wr = r.f_wr;
  assign flash_erase = r.f_erase;
  assign flash_rd = r.f_rd;

  //////////////////////////////////////////////////////////////////////////////
  // checks

  ewen_set_src_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(r.ewen) |-> $past(r.unlock) && $past(pattern_ok))
    else $error("enable status rose without a good unlock");

  load_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr && !r.ewen && paddr == iap_pkg::OFF_DATA_BASE + 12'h004 |=> $stable(r.addr))
    else $error("address stepped on a load while erase/write disabled");

  addr_inc_a: assert property (@(posedge pclk) disable iff (!presetn)
    ld && r.addr[4:0] != 5'h1F |=> r.addr == $past(r.addr) + 14'h0001)
    else $error("address did not step after a word load");

  addr_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
    ld && r.addr[4:0] == 5'h1F |=> $stable(r.addr))
    else $error("address left the page end");

  read_seq_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(r.rstart) |-> ##1 r.f_rd ##1 !r.f_rd ##1 !r.rstart && r.data[0] == $past(flash_rdata))
    else $error("read start not retired with the word");

  read_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(r.rstart) |-> $past(r.rden) && $past(idle))
    else $error("read start accepted without enable or while busy");

  write_end_a: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(r.wstart) && $past(r.fsm) != iap_pkg::ERASE |-> $past(r.fsm) == iap_pkg::CLR && $past(r.widx) == 5'h1F)
    else $error("write start cleared before the buffer was cleared");

  clear_end_a: assert property (@(posedge pclk) disable iff (!presetn)
    r.fsm == iap_pkg::CLR && r.widx == 5'h1F && r.bclear |=> !r.bclear && r.fsm == iap_pkg::IDLE)
    else $error("buffer clear bit not dropped at end of clear");

  page_addr_a: assert property (@(posedge pclk) disable iff (!presetn)
    r.f_wr |-> r.f_addr[13:5] == r.addr[13:5] && r.f_addr[4:0] == $past(r.widx))
    else $error("programmed word outside the selected page");

  high_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    r.pready && !pwrite && paddr == iap_pkg::OFF_ADDR_HIGH |-> r.prdata[31:6] == 26'h0000000)
    else $error("high address upper bits read non-zero");
endmodule : iap_flash_program_controller

// >>> logic/iap_pkg.sv
// shared constants, types and register map of the flash programming controller
package iap_pkg;
  // register byte addresses on the apb bus
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_KEY = 12'h004;
  localparam logic [11:0] OFF_AUX = 12'h008;
  localparam logic [11:0] OFF_ADDR_LOW = 12'h00C;
  localparam logic [11:0] OFF_ADDR_HIGH = 12'h010;
  localparam logic [11:0] OFF_DATA_BASE = 12'h014;
  localparam logic [11:0] OFF_INT_STAT = 12'h034;
  localparam logic [11:0] OFF_INT_MASK = 12'h038;
  localparam int unsigned DATA_REGS = 8;
  localparam int unsigned DATA_STRIDE = 4;
  // control register fields
  localparam int unsigned BIT_EWEN = 7;
  localparam int unsigned BIT_MODE_LO = 4;
  localparam int unsigned BIT_UNLOCK = 3;
  localparam int unsigned BIT_WSTART = 2;
  localparam int unsigned BIT_RDEN = 1;
  localparam int unsigned BIT_RSTART = 0;
  // aux register fields
  localparam int unsigned BIT_TSEL = 1;
  localparam int unsigned BIT_BCLEAR = 0;
  // operation mode codes
  localparam logic [2:0] MODE_WRITE = 3'h0;
  localparam logic [2:0] MODE_ERASE = 3'h1;
  localparam logic [2:0] MODE_READ = 3'h3;
  localparam logic [2:0] MODE_UNLOCK = 3'h6;
  // unlock pattern, high byte over low byte, for data pairs one to three
  localparam logic [15:0] UNLOCK_WORD1 = 16'h0400;
  localparam logic [15:0] UNLOCK_WORD2 = 16'h090D;
  localparam logic [15:0] UNLOCK_WORD3 = 16'h40C3;
  localparam logic [7:0] CHIP_RESET_KEY = 8'h55;
  localparam logic [4:0] PAGE_LAST = 5'h1F;
  // interrupt event bits
  localparam int unsigned EV_OP_DONE = 0;
  localparam int unsigned EV_RD_DONE = 1;
  localparam int unsigned EV_CLR_DONE = 2;
  localparam int unsigned EV_UNLOCK_END = 3;
  // timing
  localparam real CLK_PERIOD_NS = 5.0;
  localparam real ERASE_SHORT_MS = 3.2;
  localparam real WRITE_SHORT_MS = 2.2;
  localparam real ERASE_LONG_MS = 3.7;
  localparam real WRITE_LONG_MS = 3.0;
  localparam int unsigned ERASE_SHORT_CYC = int'(ERASE_SHORT_MS * 1.0e6 / CLK_PERIOD_NS);
  localparam int unsigned WRITE_SHORT_CYC = int'(WRITE_SHORT_MS * 1.0e6 / CLK_PERIOD_NS);
  localparam int unsigned ERASE_LONG_CYC = int'(ERASE_LONG_MS * 1.0e6 / CLK_PERIOD_NS);
  localparam int unsigned WRITE_LONG_CYC = int'(WRITE_LONG_MS * 1.0e6 / CLK_PERIOD_NS);
  localparam logic [11:0] UNLOCK_WINDOW_CYC = 12'h400;

  typedef enum logic [2:0] {
    IDLE = 3'b000,
    ERASE = 3'b001,
    WR_SHIFT = 3'b010,
    WR_WAIT = 3'b011,
    CLR = 3'b100,
    RD_ISSUE = 3'b101,
    RD_CAPT = 3'b110
  } fsm_e;

  typedef struct packed {
    logic ewen;
    logic [2:0] mode;
    logic unlock;
    logic wstart;
    logic rden;
    logic rstart;
    logic time_sel;
    logic bclear;
    logic [7:0] rst_key;
    logic [13:0] addr;
    logic [3:0][15:0] data;
    fsm_e fsm;
    logic [19:0] cnt;
    logic [11:0] ucnt;
    logic [4:0] widx;
    logic [3:0] irq_stat;
    logic [3:0] irq_mask;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic chip_rst;
    logic [13:0] f_addr;
    logic [15:0] f_wdata;
    logic f_wr;
    logic f_erase;
    logic f_rd;
  } state_s;

  // every register and flag is zero after reset, the fsm sits in idle
  localparam state_s STATE_RESET = '0;
endpackage : iap_pkg

// >>> logic/iap_write_buffer.sv
// one-page write buffer, 32 words of 16 bits, single shared port
`timescale 1ns/100ps
module iap_write_buffer (
  input wire logic pclk, // system clock
  input wire logic we, // write the addressed word
  input wire logic [4:0] idx, // word index inside the page
  input wire logic [15:0] wdata, // word to store
  output logic [15:0] rdata // word at idx, combinational
);
  // contents need no reset: software or the clear walk fills every entry before use
  logic [15:0] mem [32];

  always_ff @(posedge pclk) begin
    if (we) begin
      mem[idx] <= wdata;
    end
  end

  assign rdata = mem[idx];
endmodule : iap_write_buffer

// >>> verification/iap_flash_program_controller_tb.sv
// self-checking testbench of the flash programming controller, driven over apb
`timescale 1ns/100ps
module iap_flash_program_controller_tb;
  localparam int unsigned ESC = 40;
  localparam int unsigned WSC = 30;
  localparam int unsigned ELC = 50;
  localparam int unsigned WLC = 35;
  localparam logic [15:0] RD_WORD = 16'hA5C3;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h00000000;
  logic [3:0] pstrb = 4'hF;
  logic [31:0] prdata;
  logic pready, pslverr, irq, chip_reset_req, flash_wr, flash_erase, flash_rd;
  logic [13:0] flash_addr;
  logic [15:0] flash_wdata;
  logic [15:0] flash_rdata = 16'h0000;
  int failures = 0;
  int checked = 0;
  int wr_n = 0;
  int er_n = 0;
  int rd_n = 0;
  int key_n = 0;
  logic [13:0] wr_addr [64];
  logic [15:0] wr_data [64];
  logic [13:0] er_addr, rd_addr;
  logic last_err;
  logic [31:0] r;

  always #2.5 pclk = ~pclk;

  iap_flash_program_controller #(.ERASE_SHORT_CYC(ESC), .WRITE_SHORT_CYC(WSC), .ERASE_LONG_CYC(ELC),
    .WRITE_LONG_CYC(WLC)) u_iap_flash_program_controller (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .chip_reset_req(chip_reset_req), .flash_addr(flash_addr),
    .flash_wdata(flash_wdata), .flash_wr(flash_wr), .flash_erase(flash_erase), .flash_rd(flash_rd),
    .flash_rdata(flash_rdata));

  ////////////////////////////////////////////////////////////////////////////////
  // flash side: records strobes and answers a read one cycle after the strobe
  always @(posedge pclk) begin
    if (flash_wr === 1'b1 && wr_n < 64) begin
      wr_addr[wr_n] = flash_addr;
      wr_data[wr_n] = flash_wdata;
      wr_n++;
    end
    if (flash_erase === 1'b1) begin
      er_addr = flash_addr;
      er_n++;
    end
    if (flash_rd === 1'b1) begin
      rd_addr = flash_addr;
      rd_n++;
      flash_rdata <= RD_WORD;
    end else begin
      flash_rdata <= ~flash_rdata;
    end
    if (chip_reset_req === 1'b1) key_n++;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic finish_test;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : finish_test

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic hang(input string name);
    $display("wrong value %s expected done seen timeout", name);
    failures++;
    finish_test();
  endtask : hang

  // one apb transfer; the request stands until pready is seen high at a rising edge
  task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d, output logic [31:0] q);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) hang("pready");
    q = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [11:0] a);
    xfer(1'b0, a, 8'h00, r);
  endtask : rd

  // polls a register until the masked bits read zero
  task automatic poll(input logic [11:0] a, input logic [7:0] m);
    int n;
    n = 0;
    do begin
      rd(a);
      n++;
    end while ((r[7:0] & m) !== 8'h00 && n < 500);
    if (n >= 500) hang("status bit clear");
  endtask : poll

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset_map;
    check("irq after reset", {31'h0, irq}, 32'h0);
    rd(iap_pkg::OFF_CTRL);
    check("control reset", r, 32'h0);
    wr(iap_pkg::OFF_ADDR_HIGH, 8'hFF);
    rd(iap_pkg::OFF_ADDR_HIGH);
    check("addr high top bits", r, 32'h3F);
    wr(iap_pkg::OFF_ADDR_HIGH, 8'h00);
    rd(12'h0FC);
    check("unmapped error", {31'h0, last_err}, 32'h1);
    check("unmapped data", r, 32'h0);
    wr(iap_pkg::OFF_CTRL, 8'h80);
    rd(iap_pkg::OFF_CTRL);
    check("enable not settable", r, 32'h0);
    wr(iap_pkg::OFF_ADDR_LOW, 8'h05);
    wr(iap_pkg::OFF_DATA_BASE + 12'h004, 8'h11);
    rd(iap_pkg::OFF_ADDR_LOW);
    check("locked load no increment", r, 32'h05);
    wr(iap_pkg::OFF_KEY, iap_pkg::CHIP_RESET_KEY);
    repeat (3) @(posedge pclk);
    check("chip reset pulse", 32'(key_n), 32'h1);
  endtask : t_reset_map

  task automatic t_unlock;
    wr(iap_pkg::OFF_CTRL, 8'h68);
    wr(12'h01C, 8'h00);
    wr(12'h020, 8'h04);
    wr(12'h024, 8'h0D);
    wr(12'h028, 8'h09);
    wr(12'h02C, 8'hC3);
    wr(12'h030, 8'h40);
    repeat (2) @(posedge pclk);
    rd(iap_pkg::OFF_CTRL);
    check("enable after pattern", r & 32'h88, 32'h88);
    poll(iap_pkg::OFF_CTRL, 8'h08);
    rd(iap_pkg::OFF_CTRL);
    check("enable kept after window", r & 32'h80, 32'h80);
    rd(iap_pkg::OFF_INT_STAT);
    check("window end event", r & 32'h08, 32'h08);
    wr(iap_pkg::OFF_INT_STAT, 8'h0F);
  endtask : t_unlock

  task automatic t_clear_irq;
    wr(iap_pkg::OFF_INT_MASK, 8'h04);
    wr(iap_pkg::OFF_AUX, 8'h01);
    rd(iap_pkg::OFF_AUX);
    check("clear running", r, 32'h01);
    poll(iap_pkg::OFF_AUX, 8'h01);
    check("irq on clear done", {31'h0, irq}, 32'h1);
    wr(iap_pkg::OFF_INT_STAT, 8'h04);
    repeat (2) @(posedge pclk);
    check("irq after w1c", {31'h0, irq}, 32'h0);
    wr(iap_pkg::OFF_INT_MASK, 8'h00);
    wr(iap_pkg::OFF_AUX, 8'h01);
    poll(iap_pkg::OFF_AUX, 8'h01);
    repeat (2) @(posedge pclk);
    check("masked irq", {31'h0, irq}, 32'h0);
    rd(iap_pkg::OFF_INT_STAT);
    check("sticky clear event", r, 32'h04);
    wr(iap_pkg::OFF_INT_STAT, 8'h0F);
  endtask : t_clear_irq

  task automatic t_load_edge;
    wr(iap_pkg::OFF_ADDR_HIGH, 8'h01);
    wr(iap_pkg::OFF_ADDR_LOW, 8'h1E);
    wr(iap_pkg::OFF_DATA_BASE, 8'h34);
    rd(iap_pkg::OFF_ADDR_LOW);
    check("low byte no increment", r, 32'h1E);
    wr(iap_pkg::OFF_DATA_BASE + 12'h004, 8'h12);
    rd(iap_pkg::OFF_ADDR_LOW);
    check("high byte increments", r, 32'h1F);
    wr(iap_pkg::OFF_DATA_BASE + 12'h004, 8'h13);
    rd(iap_pkg::OFF_ADDR_LOW);
    check("stops at page end", r, 32'h1F);
    rd(iap_pkg::OFF_ADDR_HIGH);
    check("page kept", r, 32'h01);
  endtask : t_load_edge

  task automatic t_write;
    wr(iap_pkg::OFF_ADDR_LOW, 8'h20);
    wr(iap_pkg::OFF_CTRL, 8'h94);
    poll(iap_pkg::OFF_CTRL, 8'h04);
    check("erase before write", {18'h0, er_addr}, 32'h0120);
    wr(iap_pkg::OFF_DATA_BASE, 8'h34);
    wr(iap_pkg::OFF_DATA_BASE + 12'h004, 8'h12);
    wr(iap_pkg::OFF_DATA_BASE, 8'h78);
    wr(iap_pkg::OFF_DATA_BASE + 12'h004, 8'h56);
    wr_n = 0;
    wr(iap_pkg::OFF_CTRL, 8'h84);
    wr(iap_pkg::OFF_AUX, 8'h01);
    rd(iap_pkg::OFF_AUX);
    check("clear ignored while busy", r, 32'h00);
    poll(iap_pkg::OFF_CTRL, 8'h04);
    check("words per page", 32'(wr_n), 32'd32);
    check("first word addr", {18'h0, wr_addr[0]}, 32'h0120);
    check("last word addr", {18'h0, wr_addr[31]}, 32'h013F);
    check("word 0", {16'h0, wr_data[0]}, 32'h1234);
    check("word 1", {16'h0, wr_data[1]}, 32'h5678);
    check("word 2 cleared", {16'h0, wr_data[2]}, 32'h0000);
    rd(iap_pkg::OFF_INT_STAT);
    check("op done event", r & 32'h01, 32'h01);
    // nothing reloaded: the automatic clear must leave zeros behind
    wr_n = 0;
    wr(iap_pkg::OFF_CTRL, 8'h84);
    poll(iap_pkg::OFF_CTRL, 8'h04);
    check("rewrite count", 32'(wr_n), 32'd32);
    check("auto cleared word 0", {16'h0, wr_data[0]}, 32'h0000);
    check("auto cleared word 1", {16'h0, wr_data[1]}, 32'h0000);
    wr(iap_pkg::OFF_INT_STAT, 8'h0F);
  endtask : t_write

  task automatic t_erase;
    wr(iap_pkg::OFF_ADDR_HIGH, 8'h02);
    wr(iap_pkg::OFF_ADDR_LOW, 8'h45);
    er_n = 0;
    wr(iap_pkg::OFF_CTRL, 8'h94);
    poll(iap_pkg::OFF_CTRL, 8'h04);
    check("short erase cycles", 32'(er_n), 32'(ESC));
    check("erase page base", {18'h0, er_addr}, 32'h0240);
    check("no word strobes", 32'(wr_n), 32'd32);
    wr(iap_pkg::OFF_AUX, 8'h02);
    er_n = 0;
    wr(iap_pkg::OFF_CTRL, 8'h94);
    poll(iap_pkg::OFF_CTRL, 8'h04);
    check("long erase cycles", 32'(er_n), 32'(ELC));
  endtask : t_erase

  task automatic t_read;
    rd_n = 0;
    wr(iap_pkg::OFF_CTRL, 8'h82);
    wr(iap_pkg::OFF_CTRL, 8'hB3);
    poll(iap_pkg::OFF_CTRL, 8'h01);
    check("one read strobe", 32'(rd_n), 32'h1);
    check("read address", {18'h0, rd_addr}, 32'h0245);
    rd(iap_pkg::OFF_DATA_BASE);
    check("read low byte", r, {24'h0, RD_WORD[7:0]});
    rd(iap_pkg::OFF_DATA_BASE + 12'h004);
    check("read high byte", r, {24'h0, RD_WORD[15:8]});
    wr(iap_pkg::OFF_CTRL, 8'h80);
    wr(iap_pkg::OFF_CTRL, 8'hB1);
    rd(iap_pkg::OFF_CTRL);
    check("read start refused", r & 32'h01, 32'h0);
    check("no strobe when disabled", 32'(rd_n), 32'h1);
  endtask : t_read

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_reset_map();
    t_unlock();
    t_clear_irq();
    t_load_edge();
    t_write();
    t_erase();
    t_read();
    finish_test();
  end
endmodule : iap_flash_program_controller_tb
